// >>> cdac_map.svh
// Register map constants for the current DAC update control block
`ifndef CDAC_MAP_SVH
`define CDAC_MAP_SVH
`define CDAC_CTRL_ADDR      8'hb1
`define CDAC_DATA_ADDR      8'hb2
`define CDAC_CTRL_RESET     8'h70
`define CDAC_CTRL_WMASK     8'hfb
`define CDAC_EN_BIT         7
`define CDAC_SRC_HI         6
`define CDAC_SRC_LO         4
`define CDAC_CSC_BIT        3
`define CDAC_RANGE_HI       1
`define CDAC_RANGE_LO       0
`endif

// >>> cdac_pkg.sv
// Types shared by the current DAC update control block
package cdac_pkg;
  // Update source codes
  typedef enum logic [2:0] {
    CDAC_SRC_T0   = 3'h0,
    CDAC_SRC_T1   = 3'h1,
    CDAC_SRC_T2   = 3'h2,
    CDAC_SRC_T3   = 3'h3,
    CDAC_SRC_RISE = 3'h4,
    CDAC_SRC_FALL = 3'h5,
    CDAC_SRC_ANY  = 3'h6,
    CDAC_SRC_WR   = 3'h7
  } cdac_src_type;

  // Edge detector state
  typedef struct packed {
    logic syncA;
    logic syncB;
    logic prev;
    logic rise;
    logic fall;
  } cdac_edge_type;

  // Main block state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] hold;
    logic [7:0] out;
    logic       upd;
    logic [7:0] rdata;
  } cdac_state_type;
endpackage : cdac_pkg

// >>> cdac_edge_detect.sv
// Synchroniser and edge detector for the conversion-start pin
`timescale 1ns/100ps
module cdac_edge_detect
  import cdac_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      risePulse,
  output logic      fallPulse
);
  cdac_edge_type st_reg;   // Current state
  cdac_edge_type st_next;  // Next state

  // Next state: second stage takes stage one; edges look only at stage two
  always_comb begin
    st_next       = st_reg;
    st_next.syncA = pinIn;
    st_next.syncB = st_reg.syncA;
    st_next.prev  = st_reg.syncB;
    st_next.rise  = st_reg.syncB & ~st_reg.prev;
    st_next.fall  = ~st_reg.syncB & st_reg.prev;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign risePulse = st_reg.rise;
  assign fallPulse = st_reg.fall;
endmodule // cdac_edge_detect

// >>> current_dac_update_control.sv
// Control register and update logic of the second current DAC channel
`timescale 1ns/100ps
`include "cdac_map.svh"

module current_dac_update_control
  import cdac_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  input  wire logic [3:0] timerOverflow,
  input  wire logic       externalConversionStart,
  output logic            currentDac1Enable,
  output logic            currentDac1ConstantSupply,
  output logic      [1:0] currentDac1RangeSelect,
  output logic      [7:0] currentDac1OutputWord,
  output logic            currentDac1Update
);

  //****************************************************************
  // Declarations
  //****************************************************************
  cdac_state_type st_reg;     // Current state
  cdac_state_type st_next;    // Next state
  logic           startRise;  // Rising edge of start pin
  logic           startFall;  // Falling edge of start pin
  logic           ctrlWr;     // Control register write
  logic           dataWr;     // Data register write
  logic           evt;        // Selected update event
  // The edge pulses are already in the clock domain; timer strobes come
  // from logic on the same clock and need no synchroniser.

  // Address match shared by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  //****************************************************************
  // Start pin synchroniser
  //****************************************************************
  // The start pin is asynchronous; two flops settle it before any edge
  // is taken, which costs a fixed latency of four clocks to the output.
  cdac_edge_detect u_edge (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pinIn     (externalConversionStart),
    .risePulse (startRise),
    .fallPulse (startFall)
  );

  //****************************************************************
  // Next state
  //****************************************************************
  // Decode writes, pick the update event, move the latches, fill the
  // read data. A data write in the same cycle as an event sends the new
  // word, so software never sees a stale word go out after its write.
  always_comb begin
    st_next = st_reg;
    ctrlWr  = regWrite & hit(regAddr, `CDAC_CTRL_ADDR);
    dataWr  = regWrite & hit(regAddr, `CDAC_DATA_ADDR);
    case (cdac_src_type'(st_reg.ctrl[`CDAC_SRC_HI:`CDAC_SRC_LO]))
      CDAC_SRC_T0:   evt = timerOverflow[0];
      CDAC_SRC_T1:   evt = timerOverflow[1];
      CDAC_SRC_T2:   evt = timerOverflow[2];
      CDAC_SRC_T3:   evt = timerOverflow[3];
      CDAC_SRC_RISE: evt = startRise;
      CDAC_SRC_FALL: evt = startFall;
      CDAC_SRC_ANY:  evt = startRise | startFall;
      CDAC_SRC_WR:   evt = 1'b0;
      default:       evt = 1'b0;
    endcase
    if (ctrlWr) begin
      st_next.ctrl = regWdata & `CDAC_CTRL_WMASK;
    end
    if (dataWr) begin
      st_next.hold = regWdata;
    end
    st_next.upd = 1'b0;
    if (st_reg.ctrl[`CDAC_SRC_HI:`CDAC_SRC_LO] == 3'h7) begin
      if (dataWr) begin
        st_next.out = regWdata;
        st_next.upd = 1'b1;
      end
    end else if (evt) begin
      st_next.out = dataWr ? regWdata : st_reg.hold;
      st_next.upd = 1'b1;
    end
    // Read mux, unmapped address reads zero
    if (regRead && hit(regAddr, `CDAC_CTRL_ADDR)) begin
      st_next.rdata = st_reg.ctrl & `CDAC_CTRL_WMASK;
    end else if (regRead && hit(regAddr, `CDAC_DATA_ADDR)) begin
      st_next.rdata = st_reg.hold;
    end else begin
      st_next.rdata = 8'h00;
    end
  end

  //****************************************************************
  // State register
  //****************************************************************
  // Reset leaves the channel off in write-update mode with a zero word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.ctrl  <= `CDAC_CTRL_RESET;
      st_reg.hold  <= 8'h00;
      st_reg.out   <= 8'h00;
      st_reg.upd   <= 1'b0;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  //****************************************************************
  // Outputs
  //****************************************************************
  // Every output is a register field; nothing combinational after flops
  // channel enable, constant supply and range select
  assign currentDac1Enable         = st_reg.ctrl[`CDAC_EN_BIT];
  assign currentDac1ConstantSupply = st_reg.ctrl[`CDAC_CSC_BIT];
  assign currentDac1RangeSelect    =
    st_reg.ctrl[`CDAC_RANGE_HI:`CDAC_RANGE_LO];
  // output latch, its load pulse and the read data
  assign currentDac1OutputWord     = st_reg.out;
  assign currentDac1Update         = st_reg.upd;
  assign regRdata                  = st_reg.rdata;

  //****************************************************************
  // Assertions
  //****************************************************************
  // All checks run on the system clock and stand down during reset.
  // Each implication looks one clock after its cause, as the latches are flops.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Control register bits and their read path
  a_bit2_reads_zero: assert property (
    !st_reg.ctrl[2]) else $error("control bit 2 not zero");
  a_bit2_read_back: assert property (
    regRead && regAddr == `CDAC_CTRL_ADDR |=> !regRdata[2])
    else $error("control bit 2 read back as one");
  a_enable_follows_write: assert property (
    ctrlWr |=> currentDac1Enable == $past(regWdata[7]))
    else $error("enable does not follow write");
  a_enable_holds: assert property (
    !ctrlWr |=> $stable(currentDac1Enable))
    else $error("enable changed without write");
  a_range_csc: assert property (
    ctrlWr |=> currentDac1RangeSelect == $past(regWdata[1:0])
    && currentDac1ConstantSupply == $past(regWdata[3]))
    else $error("range or supply mode wrong");
  a_csc_holds: assert property (
    !ctrlWr |=> $stable(currentDac1ConstantSupply))
    else $error("supply mode changed without write");

  // Timer overflow sources
  a_timer0_update: assert property (
    st_reg.ctrl[6:4] == 3'h0 && timerOverflow[0] |=> currentDac1Update)
    else $error("timer 0 update missing");
  a_timer_update: assert property (
    st_reg.ctrl[6:4] == 3'h1 && timerOverflow[1] && !dataWr
    |=> currentDac1Update && currentDac1OutputWord == $past(st_reg.hold))
    else $error("timer update missing");

  // Start pin edge sources
  a_rise_update: assert property (
    st_reg.ctrl[6:4] == 3'h4 && startRise |=> currentDac1Update)
    else $error("rise update missing");
  a_fall_ignored: assert property (
    st_reg.ctrl[6:4] == 3'h4 && startFall && !startRise
    |=> !currentDac1Update)
    else $error("fall edge updated in rise mode");
  a_fall_update: assert property (
    st_reg.ctrl[6:4] == 3'h5 && startFall |=> currentDac1Update)
    else $error("fall update missing");
  a_any_update: assert property (
    st_reg.ctrl[6:4] == 3'h6 && (startRise || startFall)
    |=> currentDac1Update)
    else $error("edge update missing");

  // Immediate update on data write
  a_imm_update: assert property (
    dataWr && st_reg.ctrl[6:4] == 3'h7
    |=> currentDac1Update && currentDac1OutputWord == $past(regWdata))
    else $error("immediate update missing");
  a_imm_only: assert property (
    st_reg.ctrl[6:4] == 3'h7 && !dataWr |=> !currentDac1Update)
    else $error("update without write in write mode");

  // Holding latch and output latch
  a_hold_load: assert property (
    dataWr |=> st_reg.hold == $past(regWdata))
    else $error("holding latch missed write");
  a_out_stable: assert property (
    !evt && !(dataWr && st_reg.ctrl[6:4] == 3'h7)
    |=> $stable(currentDac1OutputWord))
    else $error("output changed without event");
  a_no_stray_update: assert property (
    !evt && !(dataWr && st_reg.ctrl[6:4] == 3'h7) |=> !currentDac1Update)
    else $error("update pulse without event");

  // Main scenarios worth seeing
  c_imm: cover property (dataWr && st_reg.ctrl[6:4] == 3'h7);
  c_any_edge: cover property (st_reg.ctrl[6:4] == 3'h6 && startFall);
  c_timer3: cover property (st_reg.ctrl[6:4] == 3'h3 && timerOverflow[3]);
  c_fall_mode: cover property (st_reg.ctrl[6:4] == 3'h5 && startFall);
  c_timer0: cover property (st_reg.ctrl[6:4] == 3'h0 && timerOverflow[0]);
endmodule // current_dac_update_control

// >>> tb_top.sv
// Self-checking testbench for the current DAC update control block
`timescale 1ns/100ps
`include "cdac_map.svh"
module tb_top
  import cdac_pkg::*;
;
  // **********
  // Signals
  // **********
  logic       mclk, rst_n, regWrite, regRead, extStart;
  logic [7:0] regAddr, regWdata, regRdata, outWord, got, ctrl, data, held;
  logic [3:0] timerOverflow;
  logic [1:0] outRange;
  logic       outEn, outCsc, outUpd, rising;
  int         mismatches, samplesChecked, cycles;

  current_dac_update_control u_current_dac_update_control (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .timerOverflow(timerOverflow), .externalConversionStart(extStart),
    .currentDac1Enable(outEn), .currentDac1ConstantSupply(outCsc),
    .currentDac1RangeSelect(outRange), .currentDac1OutputWord(outWord),
    .currentDac1Update(outUpd));

  // Free-running 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // **********
  // Tasks
  // **********
  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) begin regAddr <= a; regWdata <= d; regWrite <= 1'b1; end
    @(posedge mclk) regWrite <= 1'b0;
    #1;
  endtask
  // Read data lands the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) begin regAddr <= a; regRead <= 1'b1; end
    @(posedge mclk) regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  // One-cycle overflow pulse on one timer
  task automatic pulse(input int t);
    @(posedge mclk) timerOverflow <= 4'h1 << t;
    @(posedge mclk) timerOverflow <= 4'h0;
    #1;
  endtask
  // Flip the start pin and count update pulses over 8 cycles
  task automatic toggle(output logic [7:0] n);
    n = 8'h00;
    @(posedge mclk) extStart <= ~extStart;
    repeat (8) begin
      @(posedge mclk);
      #1 if (outUpd === 1'b1) n++;
    end
  endtask
  // Expected pulse count for a pin edge under a source code
  function automatic logic [7:0] hits(input logic [2:0] c, input logic r);
    return {7'h00, (c == 3'h6) || (c == 3'h4 && r) || (c == 3'h5 && !r)};
  endfunction
  // Verdict, the only exit
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog against a hang
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  // **********
  // Main sequence
  // **********
  initial begin
    {regWrite, regRead, extStart, rst_n} = 4'h0;
    {regAddr, regWdata, timerOverflow} = 20'h00000;
    void'($urandom(87));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`CDAC_CTRL_ADDR, got);
    chk(got, `CDAC_CTRL_RESET);
    chk({4'h0, outEn, outCsc, outRange}, 8'h00);
    chk(outWord, 8'h00);
    chk({7'h00, outUpd}, 8'h00);
    rd(8'h00, got);
    chk(got, 8'h00);
    // Every update source, random control and data
    for (int c = 0; c < 8; c++) begin
      ctrl = 8'($urandom);
      ctrl[6:4] = 3'(c);
      wr(`CDAC_CTRL_ADDR, ctrl);
      rd(`CDAC_CTRL_ADDR, got);
      chk(got, ctrl & `CDAC_CTRL_WMASK);
      chk({7'h00, outEn}, {7'h00, ctrl[7]});
      chk({6'h00, outRange}, {6'h00, ctrl[1:0]});
      chk({7'h00, outCsc}, {7'h00, ctrl[3]});
      held = outWord;
      data = 8'($urandom);
      wr(`CDAC_DATA_ADDR, data);
      chk(outWord, (c == 7) ? data : held);
      chk({7'h00, outUpd}, {7'h00, c == 7});
      rd(`CDAC_DATA_ADDR, got);
      chk(got, data);
      if (c < 4) begin
        pulse((c + 1) % 4);
        chk(outWord, held);
        pulse(c);
        chk(outWord, data);
        chk({7'h00, outUpd}, 8'h01);
      end else if (c < 7) begin
        repeat (2) begin
          rising = !extStart;
          toggle(got);
          chk(got, hits(3'(c), rising));
        end
        chk(outWord, data);
      end else begin
        pulse(c - 7);
        chk({7'h00, outUpd}, 8'h00);
        chk(outWord, data);
      end
    end
    wrap_up();
  end
endmodule // tb_top
